/* File: hdl/sens_irq_top.sv */
// interrupt output logic top: register slave, event sources and two pins
//////////////////////////////////////////////////////////////////////////////
// Operation
// - each pin has its own latch/pulse, polarity and enable setting
// - latch setting 0 holds the pin active until software clears it
// - latch setting 1 gives one ~50 us active pulse, then inactive
// - polarity 0 idles the pin high, low when asserted
// - polarity 1 idles the pin low, high when asserted
// - enable 0 keeps conditions off the pin; 1 lets routed ones drive it
// - release read deasserts latched pins, clears sources and summary status
// - summary flag plus origin bits in source register; host polls then releases
// - pin one and pin two each have an independent routing register
// - accel wake fires with engine on, unmasked axis above threshold for count
// - per-axis mask bits exclude accel axes from motion detection
// - field wake fires likewise, with its own engine enable and axis masks
// - buffer-full interrupt only when its engine bit in buffer control is set
// - buffer stores only selected channels whose sensor is enabled
// - sample level is readable; host avoids reading it while filling
// - source register: field motion bit 0, free fall bit 2, buffer full bit 6
// - release register at index 0x05; reading it unlatches the pins
//////////////////////////////////////////////////////////////////////////////
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sens_irq_top
  import sens_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid_in,
  input wire sens_axes_t accel_in,
  input wire sens_axes_t field_in,
  input wire logic free_fall_irq_in,
  output logic int_pin_one_out,
  output logic int_pin_two_out,
  output logic irq_out
);

  // number of set bits in a channel selection
  function automatic logic [2:0] sens_count_sel(input logic [6:0] sel);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 7; i++) begin
      n = n + {2'b00, sel[i]};
    end
    return n;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] sens_merge16(input logic [15:0] old, input logic [31:0] d,
                                               input logic [3:0] strb);
    return {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] pin_one_routing, pin_two_routing, pin_electrical_config, axis_mask_control;
  logic [7:0] engine_ctrl, motion_persist_counter, mag_persist_counter, buf_ctrl, sensor_en;
  logic [7:0] buf_level, src_flags, irq_stat, irq_mask;
  logic [15:0] acc_thresh, mag_thresh;
  logic buf_full;

  //////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic aw_held, w_held, do_write, aw_hs, w_hs, ar_hs, rd_err, wr_err, irq_release_reg;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign irq_release_reg = ar_hs && rd_idx == IDX_RELEASE;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b0;
      wr_idx <= '0;
    end else if (aw_hs) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b1;
      wr_idx <= s_axi_awaddr[ADDR_W-1:2];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid && !s_axi_awready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (w_hs) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && !s_axi_bvalid && !s_axi_wready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (wr_idx)
      IDX_ROUTE_ONE, IDX_ROUTE_TWO, IDX_ELEC, IDX_AXIS_MASK, IDX_ENGINE,
      IDX_ACC_THRESH, IDX_MAG_THRESH, IDX_ACC_COUNT, IDX_MAG_COUNT,
      IDX_BUF_CTRL, IDX_SENSOR_EN, IDX_BUF_LEVEL, IDX_IRQ_STAT,
      IDX_IRQ_MASK: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (rd_idx)
      IDX_SRC_ONE, IDX_RELEASE: rd_data[7:0] = src_flags;
      IDX_STATUS: rd_data[STAT_INT_BIT] = src_flags[SRC_SUMMARY];
      IDX_ROUTE_ONE: rd_data[7:0] = pin_one_routing;
      IDX_ROUTE_TWO: rd_data[7:0] = pin_two_routing;
      IDX_ELEC: rd_data[7:0] = pin_electrical_config;
      IDX_AXIS_MASK: rd_data[7:0] = axis_mask_control;
      IDX_ENGINE: rd_data[7:0] = engine_ctrl;
      IDX_ACC_THRESH: rd_data[15:0] = acc_thresh;
      IDX_MAG_THRESH: rd_data[15:0] = mag_thresh;
      IDX_ACC_COUNT: rd_data[7:0] = motion_persist_counter;
      IDX_MAG_COUNT: rd_data[7:0] = mag_persist_counter;
      IDX_BUF_CTRL: rd_data[7:0] = buf_ctrl;
      IDX_SENSOR_EN: rd_data[7:0] = sensor_en;
      IDX_BUF_LEVEL: rd_data[7:0] = buf_level;
      IDX_IRQ_STAT: rd_data[7:0] = irq_stat;
      IDX_IRQ_MASK: rd_data[7:0] = irq_mask;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid && !s_axi_arready) begin
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration writes
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_one_routing <= RST_BYTE;
      pin_two_routing <= RST_BYTE;
      pin_electrical_config <= RST_BYTE;
      axis_mask_control <= RST_BYTE;
      engine_ctrl <= RST_BYTE;
      acc_thresh <= RST_THRESH;
      mag_thresh <= RST_THRESH;
      motion_persist_counter <= RST_COUNT;
      mag_persist_counter <= RST_COUNT;
      buf_ctrl <= RST_BYTE;
      sensor_en <= RST_BYTE;
      irq_mask <= RST_BYTE;
    end else if (do_write) begin
      if (wr_strb[0]) begin
        unique case (wr_idx)
          IDX_ROUTE_ONE: pin_one_routing <= wr_data[7:0];
          IDX_ROUTE_TWO: pin_two_routing <= wr_data[7:0];
          IDX_ELEC: pin_electrical_config <= wr_data[7:0];
          IDX_AXIS_MASK: axis_mask_control <= wr_data[7:0];
          IDX_ENGINE: engine_ctrl <= wr_data[7:0];
          IDX_ACC_COUNT: motion_persist_counter <= wr_data[7:0];
          IDX_MAG_COUNT: mag_persist_counter <= wr_data[7:0];
          IDX_BUF_CTRL: buf_ctrl <= wr_data[7:0];
          IDX_SENSOR_EN: sensor_en <= wr_data[7:0];
          IDX_IRQ_MASK: irq_mask <= wr_data[7:0];
          default: ;
        endcase
      end
      if (wr_idx == IDX_ACC_THRESH) begin
        acc_thresh <= sens_merge16(acc_thresh, wr_data, wr_strb);
      end
      if (wr_idx == IDX_MAG_THRESH) begin
        mag_thresh <= sens_merge16(mag_thresh, wr_data, wr_strb);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event engines
  logic acc_fire, mag_fire, buf_full_irq;
  logic [7:0] events;
  sens_motion_det u_accel_motion_wake (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .sample_valid_in(sample_valid_in && sensor_en[SEN_ACCEL]),
    .axes_in(accel_in),
    .axis_mask_in(axis_mask_control[2:0]),
    .thresh_in(acc_thresh),
    .count_in(motion_persist_counter),
    .engine_on_in(engine_ctrl[ENG_ACCEL]),
    .fire_out(acc_fire)
  );

  sens_motion_det u_field_motion_wake (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .sample_valid_in(sample_valid_in && sensor_en[SEN_FIELD]),
    .axes_in(field_in),
    .axis_mask_in(axis_mask_control[5:3]),
    .thresh_in(mag_thresh),
    .count_in(mag_persist_counter),
    .engine_on_in(engine_ctrl[ENG_FIELD]),
    .fire_out(mag_fire)
  );

  // buffer fill level in bytes, two per stored channel
  logic [6:0] buf_store_sel;
  logic [8:0] buf_sum;

  assign buf_store_sel = buf_ctrl[6:0] & {sensor_en[SEN_TEMP], {3{sensor_en[SEN_FIELD]}},
                                          {3{sensor_en[SEN_ACCEL]}}};
  assign buf_sum = {1'b0, buf_level} + {5'h00, sens_count_sel(buf_store_sel), 1'b0};

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      buf_level <= RST_BYTE;
      buf_full <= 1'b0;
      buf_full_irq <= 1'b0;
    end else begin
      buf_full_irq <= 1'b0;
      if (do_write && wr_idx == IDX_BUF_LEVEL && wr_strb[0]) begin
        buf_level <= RST_BYTE;
        buf_full <= 1'b0;
      end else if (sample_valid_in && !buf_full && buf_store_sel != 7'h00) begin
        if (buf_sum > {1'b0, BUF_CAP_BYTES}) begin
          buf_full <= 1'b1;
          buf_full_irq <= buf_ctrl[BUF_FULL_ENG];
        end else begin
          buf_level <= buf_sum[7:0];
        end
      end
    end
  end

  always_comb begin
    events = 8'h00;
    events[SRC_FIELD_MOTION] = mag_fire;
    events[SRC_ACCEL_MOTION] = acc_fire;
    events[SRC_FREE_FALL] = free_fall_irq_in;
    events[SRC_BUF_FULL] = buf_full_irq;
  end

  //////////////////////////////////////////////////////////////////////////////
  // source flags, summary and system interrupt
  logic [7:0] next_src_flags;

  always_comb begin
    next_src_flags = (src_flags & ~{8{irq_release_reg}}) | events;
    next_src_flags[SRC_SUMMARY] = |(next_src_flags & SRC_EVENT_MASK);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_flags <= RST_BYTE;
    end else begin
      src_flags <= next_src_flags;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_stat <= RST_BYTE;
    end else if (do_write && wr_idx == IDX_IRQ_STAT && wr_strb[0]) begin
      irq_stat <= (irq_stat & ~wr_data[7:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // physical pins
  sens_pin_cfg_t pin_one_cfg, pin_two_cfg;
  assign pin_one_cfg = pin_electrical_config[EL_EN:EL_LATCH];
  assign pin_two_cfg = pin_electrical_config[PIN_TWO_BASE+EL_EN:PIN_TWO_BASE+EL_LATCH];

  sens_pin_drv #(
    .PULSE_LEN(PULSE_LEN)
  ) u_pin_one (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .cfg_in(pin_one_cfg),
    .pending_in(|(src_flags & pin_one_routing & SRC_EVENT_MASK)),
    .trigger_in(|(events & pin_one_routing)),
    .pin_out(int_pin_one_out)
  );

  sens_pin_drv #(
    .PULSE_LEN(PULSE_LEN)
  ) u_pin_two (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .cfg_in(pin_two_cfg),
    .pending_in(|(src_flags & pin_two_routing & SRC_EVENT_MASK)),
    .trigger_in(|(events & pin_two_routing)),
    .pin_out(int_pin_two_out)
  );

endmodule
`default_nettype wire

/* File: hdl/sens_pkg.sv */
// shared constants, types and helpers of the sensor interrupt output logic
package sens_pkg;

  // clock and pulse timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned PULSE_TIME_US = 50;
  localparam int unsigned PULSE_CYCLES = (PULSE_TIME_US * 1000) / CLK_PERIOD_NS;

  // bus geometry: byte address = 4 * register index
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W = 6;

  // register indices
  localparam logic [IDX_W-1:0] IDX_SRC_ONE = 6'h03;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h04;
  localparam logic [IDX_W-1:0] IDX_RELEASE = 6'h05;
  localparam logic [IDX_W-1:0] IDX_ROUTE_ONE = 6'h06;
  localparam logic [IDX_W-1:0] IDX_ROUTE_TWO = 6'h07;
  localparam logic [IDX_W-1:0] IDX_ELEC = 6'h08;
  localparam logic [IDX_W-1:0] IDX_AXIS_MASK = 6'h09;
  localparam logic [IDX_W-1:0] IDX_ENGINE = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_ACC_THRESH = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_MAG_THRESH = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_ACC_COUNT = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_MAG_COUNT = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_BUF_CTRL = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_SENSOR_EN = 6'h10;
  localparam logic [IDX_W-1:0] IDX_BUF_LEVEL = 6'h11;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h13;

  // source flag positions (also routing and irq status layout)
  localparam int unsigned SRC_FIELD_MOTION = 0;
  localparam int unsigned SRC_ACCEL_MOTION = 1;
  localparam int unsigned SRC_FREE_FALL = 2;
  localparam int unsigned SRC_BUF_FULL = 6;
  localparam int unsigned SRC_SUMMARY = 7;
  localparam logic [7:0] SRC_EVENT_MASK = 8'h47;
  localparam int unsigned STAT_INT_BIT = 4;

  // electrical config fields, pin two sits PIN_TWO_BASE higher
  localparam int unsigned EL_LATCH = 0;
  localparam int unsigned EL_POL = 1;
  localparam int unsigned EL_EN = 2;
  localparam int unsigned PIN_TWO_BASE = 4;

  // engine, sensor enable and buffer control fields
  localparam int unsigned ENG_ACCEL = 0;
  localparam int unsigned ENG_FIELD = 1;
  localparam int unsigned SEN_ACCEL = 0;
  localparam int unsigned SEN_FIELD = 1;
  localparam int unsigned SEN_TEMP = 6;
  localparam int unsigned BUF_FULL_ENG = 7;
  localparam logic [7:0] BUF_CAP_BYTES = 8'hFC;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_THRESH = 16'h0000;
  localparam logic [7:0] RST_COUNT = 8'h01;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } sens_axes_t;

  typedef struct packed {
    logic pin_output_enable;
    logic pin_polarity_select;
    logic latch_pulse_select;
  } sens_pin_cfg_t;

  // magnitude of a signed sample above an unsigned threshold
  function automatic logic sens_abs_above(input logic signed [15:0] v, input logic [15:0] th);
    logic [16:0] mag;
    mag = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
    return mag > {1'b0, th};
  endfunction

endpackage

/* File: hdl/sens_motion_det.sv */
// motion wake-up persistence detector for one tri-axis sensor
`timescale 1ns/1ps
`default_nettype none
module sens_motion_det
  import sens_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic sample_valid_in,
  input wire sens_axes_t axes_in,
  input wire logic [2:0] axis_mask_in,
  input wire logic [15:0] thresh_in,
  input wire logic [7:0] count_in,
  input wire logic engine_on_in,
  output logic fire_out
);

  logic [7:0] run_cnt;
  logic fired;
  logic above;
  logic [8:0] next_cnt;

  // masked axes never count as moving
  assign above = (!axis_mask_in[0] && sens_abs_above(axes_in.x, thresh_in)) ||
                 (!axis_mask_in[1] && sens_abs_above(axes_in.y, thresh_in)) ||
                 (!axis_mask_in[2] && sens_abs_above(axes_in.z, thresh_in));
  assign next_cnt = {1'b0, run_cnt} + 9'h001;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_cnt <= 8'h00;
      fired <= 1'b0;
      fire_out <= 1'b0;
    end else begin
      fire_out <= 1'b0;
      if (!engine_on_in) begin
        run_cnt <= 8'h00;
        fired <= 1'b0;
      end else if (sample_valid_in) begin
        if (above) begin
          if (next_cnt >= {1'b0, count_in} && !fired) begin
            fire_out <= 1'b1;
            fired <= 1'b1;
          end
          if (run_cnt != 8'hFF) begin
            run_cnt <= next_cnt[7:0];
          end
        end else begin
          run_cnt <= 8'h00;
          fired <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: hdl/sens_pin_drv.sv */
// output driver of one physical interrupt pin
`timescale 1ns/1ps
`default_nettype none
module sens_pin_drv
  import sens_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire sens_pin_cfg_t cfg_in,
  input wire logic pending_in,
  input wire logic trigger_in,
  output logic pin_out
);

  localparam int unsigned CNT_W = $clog2(PULSE_LEN + 1);

  logic [CNT_W-1:0] pulse_cnt;
  logic active;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulse_cnt <= '0;
    end else if (!cfg_in.latch_pulse_select || !cfg_in.pin_output_enable) begin
      pulse_cnt <= '0;
    end else if (trigger_in) begin
      pulse_cnt <= CNT_W'(PULSE_LEN);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - CNT_W'(1);
    end
  end

  always_comb begin
    if (!cfg_in.pin_output_enable) begin
      active = 1'b0;
    end else if (cfg_in.latch_pulse_select) begin
      active = pulse_cnt != '0;
    end else begin
      active = pending_in;
    end
  end

  // idle level follows polarity
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_out <= 1'b1;
    end else begin
      pin_out <= cfg_in.pin_polarity_select ? active : !active;
    end
  end

endmodule
`default_nettype wire

/* File: tb/sens_irq_monitor.sv */
// bus handshake and pin reset level checker for the interrupt output top
`timescale 1ns/1ps
`default_nettype none
module sens_irq_monitor
  import sens_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_pin_one_out,
  input wire logic int_pin_two_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence ar_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_hs;
    s_axi_bvalid && s_axi_bready;
  endsequence
  a_read_answer: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_rearm: assert property (b_hs |=> !s_axi_awready ##1 s_axi_awready)
    else $error("write address ready not restored");
  a_ar_rearm: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_arready ##1 s_axi_arready)
    else $error("read address ready not restored");
  a_unmapped_read: assert property (ar_hs ##0 s_axi_araddr[7:2] > IDX_IRQ_MASK |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_release_okay: assert property (ar_hs ##0 s_axi_araddr[7:2] == IDX_RELEASE |=>
    s_axi_rresp == RESP_OKAY)
    else $error("release read refused");
  a_pins_idle: assert property ($rose(rstn_in) |-> int_pin_one_out && int_pin_two_out)
    else $error("pins not idle high after reset");
endmodule
////////////////////////////////////////
bind sens_irq_top sens_irq_monitor #(.PULSE_LEN(PULSE_LEN)) u_mon (
  .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .int_pin_one_out(int_pin_one_out),
  .int_pin_two_out(int_pin_two_out));
`default_nettype wire

/* File: tb/sens_host_model.sv */
// host interrupt input: measures the length of each active-high run
`timescale 1ns/1ps
`default_nettype none
module sens_host_model (
  input wire logic sys_clk_in,
  input wire logic pin_in,
  output logic [15:0] run_out
);
  logic [15:0] cnt = 16'h0;
  initial run_out = 16'h0;
  // host only observes, polling and release go over the bus
  always @(posedge sys_clk_in) begin
    if (pin_in) cnt <= cnt + 16'h1;
    else if (cnt != 16'h0) begin
      run_out <= cnt;
      cnt <= 16'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_sensor_interrupt_output_logic.sv */
// self-checking bench of the sensor interrupt output logic
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_interrupt_output_logic
  import sens_pkg::*;
;
  localparam int unsigned PLEN = 20;
  logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sv = 1'b0, ff = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  sens_axes_t acc = '0, fld = '0;
  logic awready, wready, bvalid, arready, rvalid, pin1, pin2, irq;
  logic [1:0] bresp, rresp;
  logic [15:0] run;
  logic [33:0] exp_q[$];
  int bad_count = 0, check_count = 0, cyc = 0, seed = 56002, i;
  always #4 clk = ~clk;
  sens_irq_top #(.PULSE_LEN(PLEN)) u_dut (.sys_clk_in(clk), .rstn_in(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sample_valid_in(sv), .accel_in(acc), .field_in(fld),
    .free_fall_irq_in(ff), .int_pin_one_out(pin1), .int_pin_two_out(pin2), .irq_out(irq));
  sens_host_model u_host (.sys_clk_in(clk), .pin_in(pin2), .run_out(run));
  ////////////////////////////////////////
  function automatic logic [15:0] sm();
    return 16'($random(seed) % 200);
  endfunction
  task chk(input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [5:0] x, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    awaddr <= {x, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(34'(bresp), 34'(r));
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [5:0] x, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    exp_q.push_back({r, d});
    araddr <= {x, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task smp(input sens_axes_t a, input sens_axes_t f);
    acc <= a;
    fld <= f;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task ffp;
    ff <= 1'b1;
    @(posedge clk);
    ff <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task tdone(input int n);
    $display("test %0d done", n);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    if (cyc == 20000) begin
      bad_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk(34'({pin1, pin2, irq}), 34'h6);
    tdone(1);
    wr(IDX_ELEC, 32'h06);
    wr(IDX_ROUTE_ONE, 32'h04);
    wr(IDX_ROUTE_TWO, 32'h04);
    wr(IDX_IRQ_MASK, 32'h04);
    ffp;
    chk(34'({pin1, pin2, irq}), 34'h7);
    rd(IDX_SRC_ONE, 32'h84);
    rd(IDX_STATUS, 32'h10);
    rd(IDX_RELEASE, 32'h84);
    rd(IDX_SRC_ONE, 32'h00);
    rd(IDX_STATUS, 32'h00);
    chk(34'({pin1, irq}), 34'h1);
    wr(IDX_IRQ_STAT, 32'h04);
    repeat (2) @(posedge clk);
    chk(34'(irq), 34'h0);
    tdone(2);
    // pin one latched active low, pin two pulsed active high
    wr(IDX_ELEC, 32'h74);
    ffp;
    chk(34'({pin1, pin2}), 34'h1);
    repeat (30) @(posedge clk);
    chk(34'({pin2, run}), 34'(PLEN));
    rd(IDX_RELEASE, 32'h84);
    chk(34'(pin1), 34'h1);
    tdone(3);
    wr(IDX_ELEC, 32'h06);
    wr(IDX_ROUTE_ONE, 32'h02);
    wr(IDX_ENGINE, 32'h01);
    wr(IDX_SENSOR_EN, 32'h03);
    wr(IDX_ACC_THRESH, 32'h0100);
    wr(IDX_ACC_COUNT, 32'h02);
    wr(IDX_AXIS_MASK, 32'h01);
    for (i = 0; i < 3; i++) smp({16'h7000, sm(), sm()}, {3{16'h7000}});
    rd(IDX_SRC_ONE, 32'h00);
    smp({sm(), 16'hD000, sm()}, '0);
    chk(34'(pin1), 34'h0);
    smp({sm(), 16'hD000, sm()}, '0);
    chk(34'(pin1), 34'h1);
    rd(IDX_RELEASE, 32'h82);
    wr(IDX_ENGINE, 32'h02);
    wr(IDX_MAG_THRESH, 32'h0100);
    wr(IDX_AXIS_MASK, 32'h08);
    smp({sm(), sm(), sm()}, {16'h7000, sm(), sm()});
    smp({sm(), sm(), sm()}, {sm(), sm(), 16'h7000});
    rd(IDX_SRC_ONE, 32'h81);
    chk(34'(pin1), 34'h0);
    rd(IDX_RELEASE, 32'h81);
    tdone(4);
    wr(IDX_ENGINE, 32'h00);
    wr(IDX_ROUTE_ONE, 32'h40);
    wr(IDX_BUF_CTRL, 32'h7F);
    wr(IDX_SENSOR_EN, 32'h01);
    repeat (3) smp({sm(), sm(), sm()}, {sm(), sm(), sm()});
    rd(IDX_BUF_LEVEL, 32'h12);
    wr(IDX_BUF_LEVEL, 32'h00);
    wr(IDX_BUF_CTRL, 32'hFF);
    wr(IDX_SENSOR_EN, 32'h43);
    repeat (18) smp({sm(), sm(), sm()}, {sm(), sm(), sm()});
    rd(IDX_BUF_LEVEL, 32'hFC);
    chk(34'(pin1), 34'h0);
    smp({sm(), sm(), sm()}, {sm(), sm(), sm()});
    rd(IDX_SRC_ONE, 32'hC0);
    chk(34'(pin1), 34'h1);
    tdone(5);
    rd(6'h3F, 32'h0, RESP_SLVERR);
    wr(6'h3F, 32'h5A, RESP_SLVERR);
    tdone(6);
    give_verdict;
  end
endmodule
`default_nettype wire
